// *** common/acsr_consts.svh ***
`ifndef ACSR_CONSTS_SVH
`define ACSR_CONSTS_SVH
// Zero-code modulator pattern, sent MSB first
`define ACSR_ZERO_PATTERN 4'h3
`define ACSR_PATTERN_LEN 4
// Soft reset field bit positions
`define ACSR_CH0_BIT 0
`define ACSR_CH1_BIT 1
// Reset value of held data
`define ACSR_DATA_RESET 24'h000000
// Default decimation ratio in clock cycles
`define ACSR_OSR_DEFAULT 256
// Default settling length in data periods
`define ACSR_SETTLE_DEFAULT 3
`endif

// *** common/acsr_pkg.sv ***
package acsr_pkg;
	// Converter word with its channel number
	typedef struct packed {
		logic ch;
		logic [23:0] code;
	} acsr_word_type;
	typedef enum logic [1:0] {ACSR_RUN, ACSR_HELD, ACSR_SETTLE} acsr_state_type;
endpackage

// *** dv/acsr_checker.sv ***
`timescale 1ns/10ps
// ***
// Soft reset watch
// ***
module acsr_checker import acsr_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [1:0] SOFT_RESET,
	input wire logic [1:0] MOD_OUT_EN,
	input wire logic [1:0] MODULATOR_BITSTREAM_OUT,
	input wire logic [47:0] DATA_REG,
	input wire logic [1:0] DATA_READY,
	input wire logic CORE_CLK_EN,
	input wire logic SAMPLE_CLK_EN
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Three held cycles, so a pulse already in flight may still drain
	a_quiet_ch0: assert property (SOFT_RESET[0] [*3] |-> !DATA_READY[0])
		else $error("ch0 pulse while held");
	a_quiet_ch1: assert property (SOFT_RESET[1] [*3] |-> !DATA_READY[1])
		else $error("ch1 pulse while held");
	a_zero_ch0: assert property (SOFT_RESET[0] [*3] |-> DATA_REG[23:0] == 24'h0)
		else $error("ch0 data not zero");
	a_zero_ch1: assert property (SOFT_RESET[1] [*3] |-> DATA_REG[47:24] == 24'h0)
		else $error("ch1 data not zero");
	a_core_gate: assert property (CORE_CLK_EN == (SOFT_RESET != 2'h3))
		else $error("core clock enable wrong");
	a_sample_live: assert property (SAMPLE_CLK_EN)
		else $error("sample clock stopped");
	a_pulse_one: assert property (DATA_READY[0] |=> !DATA_READY[0])
		else $error("ready pulse too long");
	// Period four, two alike then two changed
	a_pattern_ch0: assert property ((SOFT_RESET[0] && MOD_OUT_EN[0]) [*8] |->
		MODULATOR_BITSTREAM_OUT[0] != $past(MODULATOR_BITSTREAM_OUT[0], 2) &&
		MODULATOR_BITSTREAM_OUT[0] == $past(MODULATOR_BITSTREAM_OUT[0], 4))
		else $error("zero pattern broken");
	c_both: cover property (SOFT_RESET == 2'h3);
	c_one: cover property (SOFT_RESET[0] && DATA_READY[1]);
	c_back: cover property ($fell(SOFT_RESET[0]) ##[1:40] DATA_READY[0]);
endmodule
bind acsr_top acsr_checker u_chk(.CLK_SYS, .RESET, .SOFT_RESET, .MOD_OUT_EN,
	.MODULATOR_BITSTREAM_OUT, .DATA_REG, .DATA_READY, .CORE_CLK_EN, .SAMPLE_CLK_EN);

// *** dv/acsr_rcv.sv ***
`timescale 1ns/10ps
// ***
// Receiver that can stall
// ***
module acsr_rcv import acsr_pkg::*; (
	input wire logic clk,
	input wire logic stall,
	input wire logic valid,
	input wire acsr_word_type word,
	output logic ready = 1'b0,
	output acsr_word_type got
);
	// Ready lags stall one edge, like a slow consumer
	always @(posedge clk) begin
		ready <= !stall;
		if (valid && ready) begin
			got <= word;
		end
	end
endmodule

// *** dv/adc_channel_soft_reset_tb.sv ***
`timescale 1ns/10ps
// ***
// Soft reset bench
// ***
module adc_channel_soft_reset_tb import acsr_pkg::*;;
	logic CLK_SYS = 1'b0, RESET = 1'b1, stall = 1'b0;
	logic [1:0] SOFT_RESET = 2'h0, DATA_READY;
	logic [1:0] MOD_OUT_EN = 2'h0, MODULATOR_BITSTREAM_OUT;
	logic [7:0] bits;
	logic [47:0] DATA_REG;
	logic OUT_VALID, OUT_READY, CORE_CLK_EN, SAMPLE_CLK_EN;
	acsr_word_type OUT_WORD, got;
	int mismatches = 0, compares = 0, n;
	initial forever #20 CLK_SYS = ~CLK_SYS;
	// Short frame keeps settling waits brief
	acsr_top #(.OSR(8)) u_dut(.CLK_SYS, .RESET, .SOFT_RESET, .PHASE_DELAY(12'h003),
		.MOD_OUT_EN, .MOD_BIT_IN(2'h2), .CONV_VALID(2'h3), .CONV_CODE(48'h0000B20000A1),
		.OUT_READY, .MODULATOR_BITSTREAM_OUT, .DATA_REG, .DATA_READY, .OUT_VALID,
		.OUT_WORD, .CORE_CLK_EN, .SAMPLE_CLK_EN);
	acsr_rcv u_rcv(.clk(CLK_SYS), .stall, .valid(OUT_VALID), .word(OUT_WORD),
		.ready(OUT_READY), .got);
	task close_out;
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task cmp(input string nm, input logic [47:0] e, input logic [47:0] a);
		compares++;
		if (a !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, a);
		end
	endtask
	// Sample 1 ns after the edge so its updates have landed
	task tick(input int k);
		repeat (k) @(posedge CLK_SYS);
		#1;
	endtask
	task hold(input logic [1:0] v);
		@(posedge CLK_SYS);
		SOFT_RESET <= v;
	endtask
	task wait_rdy(input int ch);
		n = 0;
		do begin
			tick(1);
			n++;
			if (n > 60) begin
				cmp("ready wait", 48'h1, 48'h0);
				close_out;
			end
		end while (DATA_READY[ch] !== 1'b1);
	endtask
	task run_and_stall;
		wait_rdy(0);
		cmp("ch0 data", 48'hA1, {24'h0, DATA_REG[23:0]});
		cmp("mod off", 48'h0, {46'h0, MODULATOR_BITSTREAM_OUT});
		wait_rdy(1);
		cmp("ch1 data", 48'hB2, {24'h0, DATA_REG[47:24]});
		@(posedge CLK_SYS);
		stall <= 1'b1;
		tick(24);
		cmp("stalled valid", 48'h1, {47'h0, OUT_VALID});
		@(posedge CLK_SYS);
		stall <= 1'b0;
		tick(8);
		wait_rdy(1);
		tick(3);
		cmp("drained word", 48'h10000B2, {23'h0, got});
	endtask
	task hold_one;
		int p;
		p = 0;
		bits = 8'h00;
		hold(2'h1);
		MOD_OUT_EN <= 2'h3;
		tick(2);
		cmp("ch0 cleared", 48'h0, {24'h0, DATA_REG[23:0]});
		cmp("ch1 kept", 48'hB2, {24'h0, DATA_REG[47:24]});
		repeat (24) begin
			tick(1);
			if (DATA_READY[1] === 1'b1) p++;
			bits = {bits[6:0], MODULATOR_BITSTREAM_OUT[0]};
			cmp("ch0 pulse", 48'h0, {47'h0, DATA_READY[0]});
		end
		cmp("ch1 pulses", 48'h3, 48'(p));
		cmp("zero pattern", 48'h1, {47'h0, bits inside {8'h33, 8'h66, 8'hCC, 8'h99}});
		cmp("ch1 raw bit", 48'h1, {47'h0, MODULATOR_BITSTREAM_OUT[1]});
	endtask
	task hold_both;
		hold(2'h3);
		tick(2);
		cmp("core clock", 48'h0, {47'h0, CORE_CLK_EN});
		cmp("sample clock", 48'h1, {47'h0, SAMPLE_CLK_EN});
		cmp("both cleared", 48'h0, DATA_REG);
	endtask
	// Ch1 runs first so ch0 must realign to it
	task release_seq;
		hold(2'h1);
		wait_rdy(1);
		cmp("core back", 48'h1, {47'h0, CORE_CLK_EN});
		hold(2'h0);
		wait_rdy(0);
		cmp("settle time", 48'h1, {47'h0, n <= 34});
		cmp("ch0 resumed", 48'hA1, {24'h0, DATA_REG[23:0]});
		wait_rdy(1);
		cmp("phase gap", 48'h4, 48'(n));
	endtask
	initial begin
		repeat (12) @(posedge CLK_SYS);
		RESET <= 1'b0;
		run_and_stall;
		hold_one;
		hold_both;
		release_seq;
		close_out;
	end
endmodule

// *** hdl/acsr_top.sv ***
`timescale 1ns/10ps
`include "acsr_consts.svh"
// Notes on behaviour
// [R1] Each channel enters soft reset when its field bit is set, leaves when cleared.
// [R2] In soft reset the converter keeps running but its result reads zero.
// [R3] Entering soft reset clears only that channel's data register.
// [R4] After exit, valid codes follow the filter settling time, no extra delay.
// [R5] No data-ready pulse for a channel while it is held in soft reset; a pulse from a capture just before entry still shows in the first held cycle.
// [R6] Enabled bitstream output of a held channel repeats 0011.
// [R7] Phase delay setting is kept across soft reset.
// [R8] Exiting channel realigns to configured phase relative to the running one.
// [R9] One channel held never stops the internal clock; exit resyncs to it.
// [R10] Both held gates the core clock; either leaving restores it.
// [R11] Sampling clock keeps running even with both channels held.
// [R12] Field bit 0 controls channel 0, bit 1 controls channel 1.
module acsr_top import acsr_pkg::*; #(
	parameter int OSR = `ACSR_OSR_DEFAULT,
	parameter int SETTLE = `ACSR_SETTLE_DEFAULT,
	parameter int PHASE_W = 12
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [1:0] SOFT_RESET,
	input wire logic [PHASE_W-1:0] PHASE_DELAY,
	input wire logic [1:0] MOD_OUT_EN,
	input wire logic [1:0] MOD_BIT_IN,
	input wire logic [1:0] CONV_VALID,
	input wire logic [47:0] CONV_CODE,
	input wire logic OUT_READY,
	output logic [1:0] MODULATOR_BITSTREAM_OUT,
	output logic [47:0] DATA_REG,
	output logic [1:0] DATA_READY,
	output logic OUT_VALID,
	output acsr_word_type OUT_WORD,
	output logic CORE_CLK_EN,
	output logic SAMPLE_CLK_EN
);
	localparam int CW = $clog2(OSR);
	localparam int SW = $clog2(SETTLE + 1) + 1;

	// ***************************************************
	// Decimation frame counter, never stopped by soft reset
	// ***************************************************
	logic [CW-1:0] frame_cnt, next_frame_cnt;
	logic frame_tick;
	always_comb begin
		next_frame_cnt = frame_cnt + 1'b1; // [R9]
		frame_tick = (frame_cnt == CW'(OSR - 1));
		if (frame_tick) begin
			next_frame_cnt = '0;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			frame_cnt <= '0;
		end else begin
			frame_cnt <= next_frame_cnt;
		end
	end

	// ***************************************************
	// Clock enables: core gated only when both held
	// ***************************************************
	always_comb begin
		CORE_CLK_EN = ~(SOFT_RESET[`ACSR_CH1_BIT] & SOFT_RESET[`ACSR_CH0_BIT]); // [R10]
		SAMPLE_CLK_EN = 1'b1; // [R11]
	end

	// ***************************************************
	// Buffer signals shared with the channels
	// ***************************************************
	logic [1:0] buf_valid;
	logic buf_full;
	logic [1:0] push;
	acsr_word_type push_word [2];

	// ***************************************************
	// Zero-code pattern source, shared by both channels
	// ***************************************************
	// Free-running, so the pattern phase at hold entry is arbitrary
	logic [1:0] pat_idx, next_pat_idx;
	logic [`ACSR_PATTERN_LEN-1:0] zero_pat;
	logic zero_bit;
	assign zero_pat = `ACSR_ZERO_PATTERN;

	// Step through the pattern, MSB first
	always_comb begin
		next_pat_idx = pat_idx + 2'h1;
		zero_bit = zero_pat[2'h3 - pat_idx]; // [R6]
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pat_idx <= 2'h0;
		end else begin
			pat_idx <= next_pat_idx;
		end
	end

	// ***************************************************
	// Per-channel capture ticks from the shared frame counter
	// ***************************************************
	// Phase setting is read live, so a hold never loses it and an
	// exiting channel lands back on its old slot beside the running one
	logic [1:0] ch_tick;
	always_comb begin
		ch_tick[0] = frame_tick;
		ch_tick[1] = (frame_cnt == CW'(PHASE_DELAY)); // [R7] [R8]
	end

	// ***************************************************
	// Per-channel soft reset logic
	// ***************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			acsr_state_type state, next_state;
			logic [SW-1:0] settle, next_settle;
			logic [23:0] data, next_data;
			logic rdy, next_rdy;
			logic mod, next_mod;
			logic held;
			logic running;
			logic capture;

			// Bit g of the field is channel g
			assign held = SOFT_RESET[g]; // [R12] [R1]

			// Hold, settle and run sequencing
			always_comb begin
				next_state = state;
				next_settle = settle;
				case (state)
					ACSR_RUN: begin
						if (held) begin
							next_state = ACSR_HELD;
						end
					end
					ACSR_HELD: begin
						if (!held) begin
							next_state = ACSR_SETTLE;
							next_settle = SW'(SETTLE);
						end
					end
					ACSR_SETTLE: begin
						if (held) begin
							next_state = ACSR_HELD;
						end else if (ch_tick[g]) begin
							// Settling counted in phase-aligned frames only
							next_settle = settle - 1'b1; // [R4] [R8]
							if (settle == SW'(1)) begin
								next_state = ACSR_RUN;
							end
						end
					end
					default: begin
						next_state = ACSR_HELD;
					end
				endcase
			end

			always_ff @(posedge CLK_SYS) begin
				if (RESET) begin
					state <= ACSR_RUN;
					settle <= '0;
				end else begin
					state <= next_state;
					settle <= next_settle;
				end
			end

			// Capture only while running and not being held this cycle
			assign running = (state == ACSR_RUN) & ~held;
			assign capture = running & ch_tick[g] & CONV_VALID[g];

			// Data register, ready pulse and buffer push
			always_comb begin
				next_data = data;
				next_rdy = 1'b0;
				push[g] = 1'b0;
				push_word[g] = '{ch: 1'(g), code: CONV_CODE[g*24 +: 24]};
				if (held || state == ACSR_HELD) begin
					// Cleared on entry and kept clear while held
					next_data = `ACSR_DATA_RESET; // [R2] [R3]
				end else if (capture) begin
					next_data = CONV_CODE[g*24 +: 24];
					next_rdy = 1'b1; // [R5]
					push[g] = ~buf_full; // Word dropped when buffer full, or for channel 1 when channel 0 pushes in the same cycle
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (RESET) begin
					data <= `ACSR_DATA_RESET;
					rdy <= 1'b0;
				end else begin
					data <= next_data;
					rdy <= next_rdy;
				end
			end

			// Bitstream: zero pattern while held, raw bit otherwise, low when off
			always_comb begin
				next_mod = 1'b0;
				if (MOD_OUT_EN[g]) begin
					next_mod = held ? zero_bit : MOD_BIT_IN[g]; // [R6]
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (RESET) begin
					mod <= 1'b0;
				end else begin
					mod <= next_mod;
				end
			end

			// Outputs straight from the channel flip-flops
			assign DATA_REG[g*24 +: 24] = data;
			assign DATA_READY[g] = rdy;
			assign MODULATOR_BITSTREAM_OUT[g] = mod;
		end
	endgenerate

	// ***************************************************
	// Two-entry output buffer, only channel 0 kept on a tie
	// ***************************************************
	acsr_word_type buf_word [2], next_buf_word [2];
	logic [1:0] next_buf_valid;
	logic pop;
	assign buf_full = buf_valid[1];
	assign pop = buf_valid[0] & OUT_READY;

	// Both channels aligned on one frame can only push one; channel 0 wins
	logic push_any;
	acsr_word_type push_sel;
	always_comb begin
		push_any = push[0] | push[1];
		push_sel = push[0] ? push_word[0] : push_word[1];
	end

	// Shift on pop, then append the pushed word behind what remains
	always_comb begin
		next_buf_word = buf_word;
		next_buf_valid = buf_valid;
		if (pop) begin
			next_buf_word[0] = buf_word[1];
			next_buf_valid = {1'b0, buf_valid[1]};
		end
		if (push_any) begin
			if (!next_buf_valid[0]) begin
				next_buf_word[0] = push_sel;
				next_buf_valid[0] = 1'b1;
			end else begin
				next_buf_word[1] = push_sel;
				next_buf_valid[1] = 1'b1;
			end
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			buf_valid <= 2'h0;
			buf_word[0] <= '0;
			buf_word[1] <= '0;
		end else begin
			buf_valid <= next_buf_valid;
			buf_word <= next_buf_word;
		end
	end
	assign OUT_VALID = buf_valid[0];
	assign OUT_WORD = buf_word[0];
endmodule
